// *** lct_defs.svh ***
// register offsets, field positions, reset values and codes for the channel timing block
// assumes nothing; definitions only
`ifndef LCT_DEFS_SVH
`define LCT_DEFS_SVH

`define LCT_ADDR_W 8
`define LCT_DATA_W 16

`define LCT_ADDR_CH3_FREQ_SHIFT_WORD 8'h0f
`define LCT_ADDR_CH0_SETTLE 8'h10
`define LCT_ADDR_CH1_SETTLE 8'h11
`define LCT_ADDR_CH2_SETTLE 8'h12
`define LCT_ADDR_CH3_SETTLE 8'h13
`define LCT_ADDR_CH0_CLKDIV 8'h14

`define LCT_OFFSET_RESET 16'h0000
`define LCT_SETTLE_RESET 16'h0000
`define LCT_PREDIV_RESET 2'h0
`define LCT_REFDIV_RESET 10'h000

`define LCT_PREDIV_MSB 13
`define LCT_PREDIV_LSB 12
`define LCT_REFDIV_MSB 9
`define LCT_REFDIV_LSB 0

`define LCT_PREDIV_DIV1 2'h1
`define LCT_PREDIV_DIV2 2'h2
`define LCT_REFDIV_RESERVED 10'h000

`define LCT_SETTLE_MIN_PERIODS 20'h00020
`define LCT_SETTLE_SHORT_MAX 16'h0001
`define LCT_SETTLE_MULT_DEFAULT 16

`endif

// *** lct_pkg.sv ***
// shared types for the channel timing block
// assumes lct_defs.svh sits in the same folder
`default_nettype none
package lct_pkg;
  typedef enum logic {LCT_IDLE, LCT_SETTLE} lct_settle_state_type;
  typedef logic [15:0] lct_word_type;
endpackage
`default_nettype wire

// *** lct_settle_timer.sv ***
// one channel's settling hold-off before a conversion starts
// assumes ref_tick is a one-cycle pulse per reference period on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "lct_defs.svh"

module lct_settle_timer
  import lct_pkg::*;
#(
  parameter int MULT = `LCT_SETTLE_MULT_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ref_tick,
  input wire logic [15:0] wait_count,
  input wire logic conv_req,
  input wire logic amp_ok,
  input wire logic warn_en,
  output logic conv_start,
  output logic amp_warn,
  output logic busy
);
  // product must fit the 20-bit interval counter
  if (MULT < 1 || MULT > 16) begin : g_bad_mult
    $error("lct_settle_timer: MULT must be 1..16");
  end

  localparam logic [19:0] MULT_W = 20'(MULT);

  lct_settle_state_type state_reg, state_next;
  logic [19:0] remain_reg, remain_next;
  logic start_reg, start_next;
  logic warn_reg, warn_next;
  logic [19:0] interval;

  always_comb begin
    if (wait_count <= `LCT_SETTLE_SHORT_MAX) begin
      interval = `LCT_SETTLE_MIN_PERIODS;
    end else begin
      interval = {4'h0, wait_count} * MULT_W;
    end
    state_next = state_reg;
    remain_next = remain_reg;
    start_next = 1'b0;
    warn_next = 1'b0;
    case (state_reg)
      LCT_IDLE: begin
        if (conv_req) begin
          remain_next = interval;
          state_next = LCT_SETTLE;
        end
      end
      LCT_SETTLE: begin
        if (ref_tick) begin
          if (remain_reg == 20'h00001) begin
            start_next = 1'b1;
            warn_next = ~amp_ok & warn_en;
            state_next = LCT_IDLE;
          end else begin
            remain_next = remain_reg - 20'h00001;
          end
        end
      end
      default: state_next = LCT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= LCT_IDLE;
      remain_reg <= 20'h00000;
      start_reg <= 1'b0;
      warn_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      remain_reg <= remain_next;
      start_reg <= start_next;
      warn_reg <= warn_next;
    end
  end

  assign conv_start = start_reg;
  assign amp_warn = warn_reg;
  assign busy = (state_reg == LCT_SETTLE);
endmodule // lct_settle_timer
`default_nettype wire

// *** lct_top.sv ***
// channel timing configuration: registers, ch0 dividers, ch3_freq_shift_word, settling timers
// assumes ch1..ch3 reference ticks come from sibling dividers on sys_clk
// What this block does
// - ch3_freq_shift_word frequency is word/2^16 times reference
// - wait programmed settling before starting conversion
// - unsettled amplitude at start warns when enabled
// - settle count zero or one gives 32 periods
// - predivider code 01 divides sensor by one
// - predivider code 10 divides sensor by two
// - reference frequency is master clock over divider
// - clock divider register resets both fields zero
`timescale 1ns/1ps
`default_nettype none
`include "lct_defs.svh"

module lct_top
  import lct_pkg::*;
#(
  parameter int SETTLE_MULT = `LCT_SETTLE_MULT_DEFAULT,
  parameter int CHANNELS = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sensor_osc_pin,
  input wire logic [3:0] amp_settled_pin,
  input wire logic [3:1] ref_tick_ext,
  input wire logic [3:0] conv_req,
  input wire logic amp_warn_enable,
  output logic [3:0] conv_start,
  output logic [3:0] amp_warn,
  output logic [3:0] settling,
  output logic ch0_ref_tick,
  output logic ch0_sensor_tick,
  output logic ch3_freq_shift_word_tick
);
  if (CHANNELS != 4) begin : g_bad_channels
    $error("lct_top: register map serves exactly four channels");
  end

  // ************************************************************
  // register file
  // ************************************************************
  lct_word_type ch3_freq_shift_word_reg, ch3_freq_shift_word_next;
  lct_word_type wait_count_reg [4];
  lct_word_type wait_count_next [4];
  logic [1:0] ch0_sensor_predivider_reg, ch0_sensor_predivider_next;
  logic [9:0] ch0_reference_ratio_reg, ch0_reference_ratio_next;
  lct_word_type rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  // reserved divider bits are not stored, so they read back as zero
  function automatic lct_word_type clkdiv_word(input logic [1:0] pre, input logic [9:0] ref_div);
    lct_word_type w;
    w = 16'h0000;
    w[`LCT_PREDIV_MSB:`LCT_PREDIV_LSB] = pre;
    w[`LCT_REFDIV_MSB:`LCT_REFDIV_LSB] = ref_div;
    return w;
  endfunction

  always_comb begin
    ch3_freq_shift_word_next = ch3_freq_shift_word_reg;
    for (int i = 0; i < 4; i++) begin
      wait_count_next[i] = wait_count_reg[i];
    end
    ch0_sensor_predivider_next = ch0_sensor_predivider_reg;
    ch0_reference_ratio_next = ch0_reference_ratio_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (reg_wr) begin
      if (reg_addr == `LCT_ADDR_CH3_FREQ_SHIFT_WORD) begin
        ch3_freq_shift_word_next = reg_wdata;
      end else if (reg_addr == `LCT_ADDR_CH0_SETTLE) begin
        wait_count_next[0] = reg_wdata;
      end else if (reg_addr == `LCT_ADDR_CH1_SETTLE) begin
        wait_count_next[1] = reg_wdata;
      end else if (reg_addr == `LCT_ADDR_CH2_SETTLE) begin
        wait_count_next[2] = reg_wdata;
      end else if (reg_addr == `LCT_ADDR_CH3_SETTLE) begin
        wait_count_next[3] = reg_wdata;
      end else if (reg_addr == `LCT_ADDR_CH0_CLKDIV) begin
        // reserved pairs are dropped; software keeps them zero
        ch0_sensor_predivider_next = reg_wdata[`LCT_PREDIV_MSB:`LCT_PREDIV_LSB];
        ch0_reference_ratio_next = reg_wdata[`LCT_REFDIV_MSB:`LCT_REFDIV_LSB];
      end
    end
    if (reg_rd) begin
      rvalid_next = 1'b1;
      if (reg_addr == `LCT_ADDR_CH3_FREQ_SHIFT_WORD) begin
        rdata_next = ch3_freq_shift_word_reg;
      end else if (reg_addr == `LCT_ADDR_CH0_SETTLE) begin
        rdata_next = wait_count_reg[0];
      end else if (reg_addr == `LCT_ADDR_CH1_SETTLE) begin
        rdata_next = wait_count_reg[1];
      end else if (reg_addr == `LCT_ADDR_CH2_SETTLE) begin
        rdata_next = wait_count_reg[2];
      end else if (reg_addr == `LCT_ADDR_CH3_SETTLE) begin
        rdata_next = wait_count_reg[3];
      end else if (reg_addr == `LCT_ADDR_CH0_CLKDIV) begin
        rdata_next = clkdiv_word(ch0_sensor_predivider_reg, ch0_reference_ratio_reg);
      end else begin
        rdata_next = 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch3_freq_shift_word_reg <= `LCT_OFFSET_RESET;
      for (int i = 0; i < 4; i++) begin
        wait_count_reg[i] <= `LCT_SETTLE_RESET;
      end
      ch0_sensor_predivider_reg <= `LCT_PREDIV_RESET;
      ch0_reference_ratio_reg <= `LCT_REFDIV_RESET;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      ch3_freq_shift_word_reg <= ch3_freq_shift_word_next;
      for (int i = 0; i < 4; i++) begin
        wait_count_reg[i] <= wait_count_next[i];
      end
      ch0_sensor_predivider_reg <= ch0_sensor_predivider_next;
      ch0_reference_ratio_reg <= ch0_reference_ratio_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // bit 0 sensor oscillation, bits 4:1 amplitude-settled flags
  logic [4:0] sync1_reg, sync2_reg, sync3_reg, level_reg, level_next;
  logic [4:0] pin_vec;

  assign pin_vec = {amp_settled_pin, sensor_osc_pin};

  always_comb begin
    // a level moves only once the second and third stages agree
    level_next = (~(sync2_reg ^ sync3_reg) & sync2_reg) | ((sync2_reg ^ sync3_reg) & level_reg);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      sync3_reg <= 5'h00;
      level_reg <= 5'h00;
    end else begin
      sync1_reg <= pin_vec;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= level_next;
    end
  end

  // ************************************************************
  // ch0 reference divider and sensor predivider
  // ************************************************************
  logic [9:0] ref_cnt_reg, ref_cnt_next;
  logic ref_tick_reg, ref_tick_next;
  logic osc_prev_reg, osc_prev_next;
  logic half_reg, half_next;
  logic sens_tick_reg, sens_tick_next;
  logic osc_rise;

  assign osc_rise = level_reg[0] & ~osc_prev_reg;

  always_comb begin
    ref_cnt_next = ref_cnt_reg;
    ref_tick_next = 1'b0;
    // reserved divider zero: reference held still rather than guessed
    if (ch0_reference_ratio_reg == `LCT_REFDIV_RESERVED) begin
      ref_cnt_next = 10'h000;
    end else if (ref_cnt_reg + 10'h001 >= ch0_reference_ratio_reg) begin
      ref_cnt_next = 10'h000;
      ref_tick_next = 1'b1;
    end else begin
      ref_cnt_next = ref_cnt_reg + 10'h001;
    end
    osc_prev_next = level_reg[0];
    half_next = half_reg;
    sens_tick_next = 1'b0;
    // codes 00 and 11 are undefined; no sensor tick is produced
    if (osc_rise) begin
      if (ch0_sensor_predivider_reg == `LCT_PREDIV_DIV1) begin
        sens_tick_next = 1'b1;
      end else if (ch0_sensor_predivider_reg == `LCT_PREDIV_DIV2) begin
        half_next = ~half_reg;
        sens_tick_next = half_reg;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ref_cnt_reg <= 10'h000;
      ref_tick_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      half_reg <= 1'b0;
      sens_tick_reg <= 1'b0;
    end else begin
      ref_cnt_reg <= ref_cnt_next;
      ref_tick_reg <= ref_tick_next;
      osc_prev_reg <= osc_prev_next;
      half_reg <= half_next;
      sens_tick_reg <= sens_tick_next;
    end
  end

  // ************************************************************
  // ch3_freq_shift_word phase accumulator
  // ************************************************************
  // carry rate = word / 2^16 of the ch3 reference tick rate
  logic [15:0] phase_reg, phase_next;
  logic carry_reg, carry_next;

  always_comb begin
    phase_next = phase_reg;
    carry_next = 1'b0;
    if (ref_tick_ext[3]) begin
      {carry_next, phase_next} = {1'b0, phase_reg} + {1'b0, ch3_freq_shift_word_reg};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_reg <= 16'h0000;
      carry_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      carry_reg <= carry_next;
    end
  end

  // ************************************************************
  // settling timers
  // ************************************************************
  logic [3:0] ref_tick_all;

  assign ref_tick_all = {ref_tick_ext, ref_tick_reg};

  for (genvar ch = 0; ch < 4; ch++) begin : g_settle
    lct_settle_timer #(
      .MULT(SETTLE_MULT)
    ) u_settle (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ref_tick(ref_tick_all[ch]),
      .wait_count(wait_count_reg[ch]),
      .conv_req(conv_req[ch]),
      .amp_ok(level_reg[ch + 1]),
      .warn_en(amp_warn_enable),
      .conv_start(conv_start[ch]),
      .amp_warn(amp_warn[ch]),
      .busy(settling[ch])
    );
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign ch0_ref_tick = ref_tick_reg;
  assign ch0_sensor_tick = sens_tick_reg;
  assign ch3_freq_shift_word_tick = carry_reg;
endmodule // lct_top
`default_nettype wire

// *** lct_sensor_model.sv ***
// behavioural lc sensor tank: oscillation and amplitude-settled flags
// assumes the bench gates excitation with run and sets settled per channel
`timescale 1ns/1ps
`default_nettype none
module lct_sensor_model #(
  parameter int HALF_NS = 40
) (
  input wire logic run,
  input wire logic [3:0] settled,
  output logic osc,
  output logic [3:0] amp_ok
);
  assign amp_ok = settled;
  // tank rests low with no excitation, never holds a stale level
  initial begin
    osc = 1'b0;
    forever begin
      #(HALF_NS);
      osc = run ? !osc : 1'b0;
    end
  end
endmodule // lct_sensor_model
`default_nettype wire

// *** lct_top_asserts.sv ***
// port timing checker for the channel timing block
// assumes it is bound onto lct_top, one sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module lct_top_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic [3:0] conv_req,
  input wire logic amp_warn_enable,
  input wire logic [3:0] conv_start,
  input wire logic [3:0] amp_warn,
  input wire logic [3:0] settling
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no valid");
  chk_valid_pulse: assert property (!reg_rd |=> !reg_rvalid)
    else $error("valid without read");
  chk_warn_start: assert property ((amp_warn & ~conv_start) == 4'h0)
    else $error("warning outside conversion start");
  chk_warn_gated: assert property (!$past(amp_warn_enable) |-> amp_warn == 4'h0)
    else $error("warning while reporting off");
  chk_req_settle: assert property (conv_req[0] && !settling[0] |=> settling[0])
    else $error("request did not start settling");
  chk_start_drop: assert property (conv_start[0] |-> !settling[0] && $past(settling[0]))
    else $error("start without settling");
  chk_settle_min: assert property ($rose(settling[0]) |-> !conv_start[0] [*8])
    else $error("settling ended too soon");
  chk_reset_quiet: assert property ($past(sys_rst) |-> {conv_start, amp_warn, settling} == 12'h000)
    else $error("outputs active after reset");
  cover property (conv_start[0]);
  cover property (amp_warn[0]);
  cover property (settling[0] && conv_req[0]);
endmodule // lct_top_asserts
bind lct_top lct_top_asserts u_chk (.sys_clk, .sys_rst, .reg_rd, .reg_rvalid, .conv_req,
  .amp_warn_enable, .conv_start, .amp_warn, .settling);
`default_nettype wire

// *** lct_top_tb.sv ***
// self-checking bench for lct_top with the sensor tank model
// assumes lct_top, lct_sensor_model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module lct_top_tb;
  logic sys_clk, sys_rst, reg_wr, reg_rd, run, warn_en, reg_rvalid, osc;
  logic ref_tick, sens_tick, off_tick;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [3:0] settled, amp_ok, conv_req, conv_start, amp_warn, settling;
  logic [3:1] tick_ext;
  int bad_count, checks_done, edges, sticks, aticks, rticks, oticks, r, c;
  lct_top u_dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid, .sensor_osc_pin(osc), .amp_settled_pin(amp_ok), .ref_tick_ext(tick_ext),
    .conv_req, .amp_warn_enable(warn_en), .conv_start, .amp_warn, .settling,
    .ch0_ref_tick(ref_tick), .ch0_sensor_tick(sens_tick), .ch3_freq_shift_word_tick(off_tick));
  lct_sensor_model u_tank (.run, .settled, .osc, .amp_ok);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge osc) edges++;
  always @(posedge sys_clk) begin
    if (sens_tick === 1'b1) sticks++;
    if (ref_tick === 1'b1) aticks++;
    if ((ref_tick & settling[0]) === 1'b1) rticks++;
    if (off_tick === 1'b1) oticks++;
  end
  // ****************
  // tasks
  // ****************
  task automatic compare(string name, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hang(int n, int bound);
    if (n >= bound) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    compare("read valid", 16'h0001, {15'h0000, reg_rvalid});
    compare("read data", exp, reg_rdata);
  endtask
  // sixteen tank edges, then idle long enough for the input filter
  task automatic sense(logic [15:0] exp);
    int n;
    n = 0;
    edges = 0;
    sticks = 0;
    run = 1'b1;
    while (edges < 16 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    run = 1'b0;
    hang(n, 400);
    repeat (30) @(negedge sys_clk);
    compare("sensor ticks", exp, sticks[15:0]);
  endtask
  function automatic int settle_n(int cnt);
    return cnt <= 1 ? 32 : cnt * 16;
  endfunction
  // ****************
  // main sequence
  // ****************
  initial begin
    {sys_rst, reg_wr, reg_rd, run, warn_en} = 5'h10;
    {reg_addr, reg_wdata, settled, conv_req, tick_ext} = '0;
    void'($urandom(32'h3826));
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int a = 8'h0f; a <= 8'h14; a++) rd(a[7:0], 16'h0000);
    rd(8'h20, 16'h0000);
    sense(16'h0000);
    // divider still at its reset zero: reference must stay still
    compare("reference ticks idle", 16'h0000, aticks[15:0]);
    wr(8'h14, 16'h2001);
    sense(16'h0008);
    wr(8'h14, 16'h1001);
    sense(16'h0010);
    wr(8'h14, 16'h3001);
    sense(16'h0000);
    for (int a = 8'h0f; a <= 8'h13; a++) begin
      d = 16'($urandom);
      wr(a[7:0], d);
      rd(a[7:0], d);
    end
    wr(8'h20, 16'hffff);
    rd(8'h20, 16'h0000);
    r = $urandom_range(8, 1);
    d = {2'b00, 2'($urandom), 2'b00, 10'(r)};
    wr(8'h14, d);
    rd(8'h14, d);
    repeat (20) @(negedge sys_clk);
    aticks = 0;
    repeat (r * 10) @(negedge sys_clk);
    compare("reference ticks", 16'd10, aticks[15:0]);
    wr(8'h14, 16'h2002);
    for (int i = 0; i < 5; i++) begin
      c = (i == 4) ? $urandom_range(9, 3) : i;
      wr(8'h10, 16'(c));
      {settled[0], warn_en} = 2'(i);
      repeat (8) @(negedge sys_clk);
      rticks = 0;
      conv_req = 4'h1;
      repeat (2) @(negedge sys_clk);
      conv_req = 4'h0;
      r = 0;
      while (conv_start[0] !== 1'b1 && r < 3000) begin
        @(negedge sys_clk);
        r++;
      end
      hang(r, 3000);
      compare("settle ticks", 16'(settle_n(c)), rticks[15:0]);
      compare("amp warn", {15'h0000, warn_en & ~settled[0]}, {15'h0000, amp_warn[0]});
    end
    for (int j = 0; j < 2; j++) begin
      wr(8'h0f, 16'h4000 << j);
      oticks = 0;
      conv_req = 4'he;
      repeat (8) begin
        @(negedge sys_clk);
        tick_ext = 3'b111;
        @(negedge sys_clk);
        tick_ext = 3'b000;
        conv_req = 4'h0;
      end
      repeat (5) @(negedge sys_clk);
      compare("offset carries", 16'd2 << j, oticks[15:0]);
    end
    // sixteen ticks stay below the 32-period minimum, so ch1..ch3 still wait
    compare("far channels", 16'h0007, {7'h00, amp_warn[3:1], conv_start[3:1], settling[3:1]});
    report_and_stop();
  end
endmodule // lct_top_tb
`default_nettype wire
